//--- tb_top.sv
// self-checking bench for the timer capture/compare block
// assumes tcc_top, tcc_dma_model and the bound checker are compiled before
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import tcc_pkg::*;
	logic clk = 1'h0;
	logic rst_n = 1'h0;
	logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd_last;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
	logic s_axi_bready = 1'h1, s_axi_rready = 1'h1;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic capture_pin = 1'h0, top_irq_hold = 1'h0, compare_pin, irq;
	tcc_dma_req_s dma_req;
	tcc_dma_rsp_s dma_rsp;
	logic stall = 1'h0, load = 1'h0, foreign = 1'h0;
	logic [15:0] reload_word = '0, cval, kval;
	logic [7:0] block_len = '0;
	logic [34:0] rq[$];
	logic [34:0] re;
	logic [15:0] dq[$];
	int mismatches = 0, num_checks = 0, seed = 32'hC9FCBF79;
	always #5 clk = ~clk;
	tcc_top dut (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .capture_pin, .compare_pin, .dma_req, .dma_rsp, .top_irq_hold, .irq);
	tcc_dma_model u_dma (.clk, .rst_n, .dma_req, .dma_rsp, .stall, .reload_word, .block_len,
		.load, .foreign);
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
		num_checks++;
		if (e !== g) begin
			mismatches++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// address and data offered together, each released once taken
	task automatic wr(input logic [9:0] idx, input logic [31:0] d, input logic [1:0] er);
		s_axi_awaddr <= {idx, 2'h0};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		// release only a channel still offered, so a following call never re-drives it
		do begin
			@(posedge clk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid);
		chk("bresp", er, s_axi_bresp);
	endtask
	task automatic rd(input logic [9:0] idx, input logic ck, input logic [33:0] e);
		rq.push_back({ck, e});
		s_axi_araddr <= {idx, 2'h0};
		s_axi_arvalid <= 1'h1;
		do @(posedge clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		do @(posedge clk); while (!s_axi_rvalid);
		rd_last = s_axi_rdata;
	endtask
	// one extra edge so a register write has landed before irq is looked at
	task automatic irq_is(input logic e);
		@(posedge clk);
		chk("irq", e, irq);
	endtask
	// pin held well past the synchroniser's agreement window
	task automatic pulse(input logic dm);
		if (dm) dq.push_back(kval);
		capture_pin <= 1'h1;
		repeat (12) @(posedge clk);
		capture_pin <= 1'h0;
		repeat (12) @(posedge clk);
	endtask
	task automatic blk(input logic [7:0] n);
		block_len <= n;
		load <= 1'h1;
		@(posedge clk);
		load <= 1'h0;
	endtask
	task automatic fdone;
		foreign <= 1'h1;
		@(posedge clk);
		foreign <= 1'h0;
		repeat (3) @(posedge clk);
	endtask
	// results are matched against the oldest note
	always @(posedge clk) begin
		if (s_axi_rvalid && s_axi_rready) begin
			re = rq.pop_front();
			if (re[34]) chk("read", re[33:0], {s_axi_rresp, s_axi_rdata});
		end
		if (dma_req.req && dma_rsp.ack && dma_req.sel == CH_CAPTURE)
			chk("dma word", dq.pop_front(), dma_req.wdata);
	end
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		report_and_stop();
	end
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		rd(IDX_MASK, 1'h1, {RESP_OKAY, 32'h0});
		rd(IDX_COMPARE, 1'h1, {RESP_OKAY, 32'hFFFF});
		rd(10'h03F, 1'h1, {RESP_SLVERR, 32'h0});
		wr(10'h03F, 32'h1, RESP_SLVERR);
		$display("test reset done");
		cval = 16'h0020 + 16'($random(seed) & 32'h1F);
		reload_word <= cval + 16'h0040;
		blk(8'h01);
		wr(IDX_IRQ_EN, 32'hF, RESP_OKAY);
		wr(IDX_MASK, 32'h8, RESP_OKAY);
		wr(IDX_COMPARE, {16'h0, cval}, RESP_OKAY);
		wr(IDX_CTRL, 32'h1, RESP_OKAY);
		repeat (2) @(compare_pin);
		@(posedge clk);
		chk("compare pin", 34'h0, compare_pin);
		rd(IDX_COMPARE, 1'h1, {RESP_OKAY, 16'h0, cval + 16'h0040});
		rd(IDX_MASK, 1'h1, {RESP_OKAY, 32'h0});
		rd(IDX_STATUS, 1'h1, {RESP_OKAY, 32'h6});
		irq_is(1'h1);
		wr(IDX_IRQ_EN, 32'h0, RESP_OKAY);
		irq_is(1'h0);
		wr(IDX_IRQ_EN, 32'hF, RESP_OKAY);
		irq_is(1'h1);
		wr(IDX_STATUS, 32'hF, RESP_OKAY);
		irq_is(1'h0);
		$display("test compare done");
		wr(IDX_CTRL, 32'h0, RESP_OKAY);
		rd(IDX_COUNT, 1'h0, 34'h0);
		kval = rd_last[15:0];
		blk(8'h02);
		wr(IDX_MASK, 32'h40, RESP_OKAY);
		pulse(1'h1);
		rd(IDX_MASK, 1'h1, {RESP_OKAY, 32'h40});
		pulse(1'h1);
		rd(IDX_MASK, 1'h1, {RESP_OKAY, 32'h0});
		pulse(1'h0);
		rd(IDX_STATUS, 1'h1, {RESP_OKAY, 32'h5});
		rd(IDX_CAPTURE, 1'h1, {RESP_OKAY, 16'h0, kval});
		wr(IDX_STATUS, 32'hF, RESP_OKAY);
		$display("test capture done");
		stall <= 1'h1;
		wr(IDX_MASK, 32'h40, RESP_OKAY);
		pulse(1'h0);
		fdone();
		chk("req kept", 34'h1, dma_req.req);
		rd(IDX_MASK, 1'h1, {RESP_OKAY, 32'h40});
		wr(IDX_CTRL, 32'h2, RESP_OKAY);
		fdone();
		chk("req killed", 34'h0, dma_req.req);
		rd(IDX_MASK, 1'h1, {RESP_OKAY, 32'h0});
		rd(IDX_STATUS, 1'h1, {RESP_OKAY, 32'h8});
		// block not finished yet the enable is gone: the event comes as an interrupt
		blk(8'h02);
		pulse(1'h0);
		rd(IDX_STATUS, 1'h1, {RESP_OKAY, 32'h9});
		rd(IDX_CAPTURE, 1'h1, {RESP_OKAY, 16'h0, kval});
		blk(8'h01);
		wr(IDX_MASK, 32'h40, RESP_OKAY);
		wr(IDX_STATUS, 32'hF, RESP_OKAY);
		wr(IDX_CTRL, 32'h0, RESP_OKAY);
		stall <= 1'h0;
		$display("test foreign done");
		blk(8'h01);
		top_irq_hold <= 1'h1;
		pulse(1'h1);
		chk("req held", 34'h0, dma_req.req);
		top_irq_hold <= 1'h0;
		while (dq.size() != 0) @(posedge clk);
		repeat (4) @(posedge clk);
		rd(IDX_MASK, 1'h1, {RESP_OKAY, 32'h0});
		$display("test hold done");
		report_and_stop();
	end
endmodule
`default_nettype wire

//--- tcc_assertions.sv
// concurrent checks on the ports of the timer capture/compare block
// assumes it is bound into tcc_top, one clock domain
`timescale 1ns/1ps
`default_nettype none
module tcc_assertions (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	// pins, dma and interrupt
	input wire logic capture_pin,
	input wire logic compare_pin,
	input wire tcc_pkg::tcc_dma_req_s dma_req,
	input wire tcc_pkg::tcc_dma_rsp_s dma_rsp,
	input wire logic top_irq_hold,
	input wire logic irq
);
	import tcc_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// a capture request stands until answered, killed or held off
	property p_req_stands;
		dma_req.req && dma_req.sel == CH_CAPTURE && !dma_rsp.ack && !dma_rsp.done && !top_irq_hold
		|=> top_irq_hold || (dma_req.req && dma_req.sel == CH_CAPTURE);
	endproperty
	a_req_stands: assert property (p_req_stands) else $error("dma request dropped");
	property p_hold_gate;
		top_irq_hold |-> !dma_req.req;
	endproperty
	a_hold_gate: assert property (p_hold_gate) else $error("request under hold");
	// one match per compare value, so the pin cannot chatter
	property p_pin_quiet;
		$changed(compare_pin) |=> $stable(compare_pin)[*8];
	endproperty
	a_pin_quiet: assert property (p_pin_quiet) else $error("compare pin chatter");
	// synchroniser plus filter delay bounds the reaction
	property p_event_served;
		$rose(capture_pin) && !top_irq_hold |-> ##[1:10] (dma_req.req || irq);
	endproperty
	a_event_served: assert property (p_event_served) else $error("event dropped");
	// the flag only goes away through a register write
	property p_irq_sticky;
		irq && !s_axi_awvalid && !s_axi_wvalid && !s_axi_bvalid |=> irq || s_axi_bvalid;
	endproperty
	a_irq_sticky: assert property (p_irq_sticky) else $error("irq fell by itself");
	property p_wr_answer;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid;
	endproperty
	a_wr_answer: assert property (p_wr_answer) else $error("write not answered");
	property p_rd_stands;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
	endproperty
	a_rd_stands: assert property (p_rd_stands) else $error("read answer moved");
	property p_err_zero;
		s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0;
	endproperty
	a_err_zero: assert property (p_err_zero) else $error("refused read with data");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind tcc_top tcc_assertions u_chk (.clk, .rst_n, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_rvalid, .s_axi_rready,
	.s_axi_rdata, .s_axi_rresp, .capture_pin, .compare_pin, .dma_req, .dma_rsp,
	.top_irq_hold, .irq);
`default_nettype wire

//--- tcc_dma_model.sv
// behavioural dma controller facing the timer block
// assumes the same clock; the bench steers stalls and foreign block ends
`timescale 1ns/1ps
`default_nettype none
module tcc_dma_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// block under test
	input wire tcc_pkg::tcc_dma_req_s dma_req,
	output var tcc_pkg::tcc_dma_rsp_s dma_rsp,
	// bench controls
	input wire logic stall,
	input wire logic [15:0] reload_word,
	input wire logic [7:0] block_len,
	input wire logic load,
	input wire logic foreign
);
	import tcc_pkg::*;
	logic [7:0] cnt_reg;
	logic [1:0] wait_reg;
	////////////////////////////////////////////////////////////////////////////////
	// one word per ack after a short arbitration wait; done follows the last word
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dma_rsp <= '0;
			cnt_reg <= 8'h00;
			wait_reg <= 2'h0;
		end else begin
			dma_rsp.ack <= 1'h0;
			dma_rsp.rdata <= ~dma_rsp.rdata; // stale word flips each cycle outside an ack
			dma_rsp.done <= foreign;
			dma_rsp.done_id <= foreign ? 3'h5 : 3'h0; // 5 stands for another requester
			wait_reg <= (dma_req.req && !stall) ? wait_reg + 2'h1 : 2'h0;
			if (load) cnt_reg <= block_len;
			// no other requester competes here: the timer wins arbitration whenever stall is low
			if (dma_req.req && !stall && wait_reg == 2'h2 && !dma_rsp.ack) begin
				dma_rsp.ack <= 1'h1;
				dma_rsp.rdata <= reload_word;
				wait_reg <= 2'h0;
			end
			if (dma_rsp.ack && dma_req.req) begin
				cnt_reg <= cnt_reg - 8'h01;
				dma_rsp.done <= (cnt_reg == 8'h01);
				dma_rsp.done_sel <= dma_req.sel;
			end
		end
	end
endmodule
`default_nettype wire

//--- tcc_pkg.sv
// constants, field layouts and carrier types of the timer capture/compare block
// assumes one 100 MHz clock and an on-chip dma controller on the same clock
//
// Summary of operation
// - 16-bit counter with capture and compare channel
// - capture event latches counter into capture value
// - compare match toggles the compare output pin
// - every channel event raises interrupt or dma
// - mask bit 6 capture dma, bit 3 compare
// - capture dma enable set: captured value goes dma
// - compare dma enable set: dma reloads compare value
// - dma moves the word without processor help
// - own block done clears matching dma enable
// - cleared enable: events raise interrupts instead
// - only own block done clears; legacy mode wrong
// - intervening higher priority also loses pending request
// - top level interrupt delays pending dma request
package tcc_pkg;

	localparam int CNT_W = 16;
	localparam int ADDR_W = 12;
	localparam int ID_W = 3;

	// register indices; byte address is four times the index
	localparam logic [9:0] IDX_CTRL = 10'h000;
	localparam logic [9:0] IDX_STATUS = 10'h001;
	localparam logic [9:0] IDX_IRQ_EN = 10'h002;
	localparam logic [9:0] IDX_COUNT = 10'h003;
	localparam logic [9:0] IDX_CAPTURE = 10'h004;
	localparam logic [9:0] IDX_COMPARE = 10'h005;
	localparam logic [9:0] IDX_MASK = 10'h0FF;

	// control register fields
	localparam int CTRL_RUN = 0;
	localparam int CTRL_LEGACY = 1;
	localparam int CTRL_PRESC_LSB = 4;
	localparam int PRESC_W = 4;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// irq/dma mask register fields
	localparam int MASK_CMP_DMA = 3;
	localparam int MASK_CAP_DMA = 6;
	localparam logic [7:0] MASK_RESET = 8'h00;

	// status register: sticky, write one to clear
	localparam int ST_W = 4;
	localparam int ST_CAP = 0;
	localparam int ST_CMP = 1;
	localparam int ST_DONE = 2;
	localparam int ST_LOST = 3;

	localparam logic [CNT_W-1:0] COMPARE_RESET = 16'hFFFF;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic {
		CH_CAPTURE,
		CH_COMPARE
	} tcc_chan_e;

	// request side towards the dma controller
	typedef struct packed {
		logic req;
		tcc_chan_e sel;
		logic [CNT_W-1:0] wdata;
	} tcc_dma_req_s;

	// answer side from the dma controller
	typedef struct packed {
		logic ack;
		logic [CNT_W-1:0] rdata;
		logic done;
		logic [ID_W-1:0] done_id;
		tcc_chan_e done_sel;
	} tcc_dma_rsp_s;

endpackage

//--- tcc_sync3.sv
// three-stage synchroniser with agreement filter for one pin
// assumes the pin is asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
module tcc_sync3 (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// pin and filtered level
	input wire logic pin,
	output logic level
);
	logic s1_reg, s2_reg, s3_reg, level_reg, level_next;

	// level follows only once stages two and three agree
	always_comb begin
		level_next = (s2_reg == s3_reg) ? s3_reg : level_reg;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
			level_reg <= 1'b0;
		end else begin
			s1_reg <= pin;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			level_reg <= level_next;
		end
	end

	assign level = level_reg;
endmodule
`default_nettype wire

//--- tcc_top.sv
// capture/compare channel 0 of an event timer with interrupt or dma per event
// assumes an axi4-lite master and a dma controller clocked by clk
`timescale 1ns/1ps
`default_nettype none
module tcc_top #(
	parameter logic [tcc_pkg::ID_W-1:0] OWN_ID = 3'h0
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// axi4-lite write channels
	input wire logic [tcc_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read channels
	input wire logic [tcc_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// timer pins
	input wire logic capture_pin,
	output logic compare_pin,
	// dma controller
	output var tcc_pkg::tcc_dma_req_s dma_req,
	input wire tcc_pkg::tcc_dma_rsp_s dma_rsp,
	input wire logic top_irq_hold,
	// interrupt
	output logic irq
);
	import tcc_pkg::*;

	// true when a byte address selects the register at index idx
	function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [9:0] idx);
		reg_hit = (addr[ADDR_W-1:2] == idx);
	endfunction

	// byte-lane merge of a write into the low bits of a register
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
			input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		merge = r;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// bus slave

	logic aw_hold_reg, aw_hold_next, w_hold_reg, w_hold_next;
	logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;
	logic [31:0] w_data_reg, w_data_next;
	logic [3:0] w_strb_reg, w_strb_next;
	logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
	logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;
	logic wr_fire, wr_mapped, rd_mapped;
	logic [31:0] rd_word;

	// registers as seen by the bus
	logic [7:0] ctrl_reg, ctrl_next, mask_reg, mask_next;
	logic [ST_W-1:0] status_reg, status_next, irq_en_reg, irq_en_next;
	logic [CNT_W-1:0] count_reg, count_next, capture_reg, capture_next;
	logic [CNT_W-1:0] compare_reg, compare_next;

	assign wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;

	// address decode shared by the write response and the read mux
	always_comb begin
		wr_mapped = reg_hit(aw_addr_reg, IDX_CTRL) || reg_hit(aw_addr_reg, IDX_STATUS)
			|| reg_hit(aw_addr_reg, IDX_IRQ_EN) || reg_hit(aw_addr_reg, IDX_COMPARE)
			|| reg_hit(aw_addr_reg, IDX_MASK) || reg_hit(aw_addr_reg, IDX_COUNT)
			|| reg_hit(aw_addr_reg, IDX_CAPTURE);
		rd_mapped = 1'b1;
		rd_word = 32'h0000_0000;
		if (reg_hit(s_axi_araddr, IDX_CTRL)) begin
			rd_word[7:0] = ctrl_reg;
		end else if (reg_hit(s_axi_araddr, IDX_STATUS)) begin
			rd_word[ST_W-1:0] = status_reg;
		end else if (reg_hit(s_axi_araddr, IDX_IRQ_EN)) begin
			rd_word[ST_W-1:0] = irq_en_reg;
		end else if (reg_hit(s_axi_araddr, IDX_COUNT)) begin
			rd_word[CNT_W-1:0] = count_reg;
		end else if (reg_hit(s_axi_araddr, IDX_CAPTURE)) begin
			rd_word[CNT_W-1:0] = capture_reg;
		end else if (reg_hit(s_axi_araddr, IDX_COMPARE)) begin
			rd_word[CNT_W-1:0] = compare_reg;
		end else if (reg_hit(s_axi_araddr, IDX_MASK)) begin
			rd_word[7:0] = mask_reg;
		end else begin
			rd_mapped = 1'b0;
		end
	end

	// address and data are taken in either order; one write and one read in flight
	always_comb begin
		aw_hold_next = aw_hold_reg;
		aw_addr_next = aw_addr_reg;
		w_hold_next = w_hold_reg;
		w_data_next = w_data_reg;
		w_strb_next = w_strb_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg;
		rresp_next = rresp_reg;
		rdata_next = rdata_reg;
		if (s_axi_awvalid && !aw_hold_reg) begin
			aw_hold_next = 1'b1;
			aw_addr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_hold_reg) begin
			w_hold_next = 1'b1;
			w_data_next = s_axi_wdata;
			w_strb_next = s_axi_wstrb;
		end
		if (wr_fire) begin
			aw_hold_next = 1'b0;
			w_hold_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = wr_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
		if (s_axi_arvalid && !rvalid_reg) begin
			rvalid_next = 1'b1;
			rdata_next = rd_word;
			rresp_next = rd_mapped ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_next = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_hold_reg <= 1'b0;
			aw_addr_reg <= '0;
			w_hold_reg <= 1'b0;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
			rvalid_reg <= 1'b0;
			rresp_reg <= RESP_OKAY;
			rdata_reg <= 32'h0000_0000;
		end else begin
			aw_hold_reg <= aw_hold_next;
			aw_addr_reg <= aw_addr_next;
			w_hold_reg <= w_hold_next;
			w_data_reg <= w_data_next;
			w_strb_reg <= w_strb_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rresp_reg <= rresp_next;
			rdata_reg <= rdata_next;
		end
	end

	assign s_axi_awready = !aw_hold_reg;
	assign s_axi_wready = !w_hold_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = rdata_reg;

	////////////////////////////////////////////////////////////////////////////////
	// timer core and dma handshake

	logic cap_level, cap_level_d_reg, cap_edge, tick, cap_evt, cmp_evt;
	logic [PRESC_W-1:0] div_reg, div_next;
	logic pin_reg, pin_next;
	logic cap_pend_reg, cap_pend_next, cmp_pend_reg, cmp_pend_next;
	logic dma_busy, serve_ack, foreign_done;
	tcc_chan_e serve_sel;
	logic [ST_W-1:0] st_set, st_clr;
	logic [31:0] wword;

	tcc_sync3 u_cap_sync (
		.clk(clk),
		.rst_n(rst_n),
		.pin(capture_pin),
		.level(cap_level)
	);

	assign cap_edge = cap_level && !cap_level_d_reg;
	assign tick = ctrl_reg[CTRL_RUN]
		&& (div_reg == ctrl_reg[CTRL_PRESC_LSB +: PRESC_W]);
	assign cap_evt = cap_edge;
	assign cmp_evt = tick && (count_reg == compare_reg);
	// capture is served first; a top-level interrupt holds the request back
	assign dma_busy = (cap_pend_reg || cmp_pend_reg) && !top_irq_hold;
	assign serve_sel = cap_pend_reg ? CH_CAPTURE : CH_COMPARE;
	assign serve_ack = dma_busy && dma_rsp.ack;
	assign foreign_done = dma_rsp.done && (dma_rsp.done_id != OWN_ID);

	always_comb begin
		ctrl_next = ctrl_reg;
		mask_next = mask_reg;
		irq_en_next = irq_en_reg;
		count_next = count_reg;
		capture_next = capture_reg;
		compare_next = compare_reg;
		div_next = div_reg;
		pin_next = pin_reg;
		cap_pend_next = cap_pend_reg;
		cmp_pend_next = cmp_pend_reg;
		st_set = '0;
		st_clr = '0;
		wword = 32'h0000_0000;
		// prescaled 16-bit up counter
		if (ctrl_reg[CTRL_RUN]) begin
			div_next = tick ? '0 : div_reg + 1'b1;
		end
		if (tick) begin
			count_next = count_reg + 1'b1;
		end
		if (cmp_evt) begin
			pin_next = !pin_reg;
		end
		if (cap_evt) begin
			capture_next = count_reg;
		end
		// word moved by the dma controller, no processor involved
		if (serve_ack) begin
			if (serve_sel == CH_CAPTURE) begin
				cap_pend_next = 1'b0;
			end else begin
				cmp_pend_next = 1'b0;
				compare_next = dma_rsp.rdata;
			end
		end
		// a block done tagged with our identity ends our dma; in legacy mode a foreign one ends it too
		if (dma_rsp.done && (dma_rsp.done_id == OWN_ID)) begin
			st_set[ST_DONE] = 1'b1;
			if (dma_rsp.done_sel == CH_CAPTURE) begin
				mask_next[MASK_CAP_DMA] = 1'b0;
			end else begin
				mask_next[MASK_CMP_DMA] = 1'b0;
			end
		end else if (foreign_done && ctrl_reg[CTRL_LEGACY] && dma_busy) begin
			// legacy mode: a foreign block done kills our pending request
			st_set[ST_LOST] = 1'b1;
			if (serve_sel == CH_CAPTURE) begin
				mask_next[MASK_CAP_DMA] = 1'b0;
				cap_pend_next = 1'b0;
			end else begin
				mask_next[MASK_CMP_DMA] = 1'b0;
				cmp_pend_next = 1'b0;
			end
		end
		// route each event to dma or, failing that, to the interrupt
		if (cap_evt) begin
			if (mask_reg[MASK_CAP_DMA] && !cap_pend_reg) begin
				cap_pend_next = 1'b1;
			end else begin
				st_set[ST_CAP] = 1'b1;
			end
		end
		if (cmp_evt) begin
			if (mask_reg[MASK_CMP_DMA] && !cmp_pend_reg) begin
				cmp_pend_next = 1'b1;
			end else begin
				st_set[ST_CMP] = 1'b1;
			end
		end
		// software writes come last so a re-enable overrides a same-cycle clear
		if (wr_fire) begin
			if (reg_hit(aw_addr_reg, IDX_CTRL)) begin
				wword = merge({24'h000000, ctrl_reg}, w_data_reg, w_strb_reg);
				ctrl_next = wword[7:0];
			end else if (reg_hit(aw_addr_reg, IDX_IRQ_EN)) begin
				wword = merge({28'h0000000, irq_en_reg}, w_data_reg, w_strb_reg);
				irq_en_next = wword[ST_W-1:0];
			end else if (reg_hit(aw_addr_reg, IDX_COMPARE)) begin
				wword = merge({16'h0000, compare_reg}, w_data_reg, w_strb_reg);
				compare_next = wword[CNT_W-1:0];
			end else if (reg_hit(aw_addr_reg, IDX_MASK)) begin
				wword = merge({24'h000000, mask_reg}, w_data_reg, w_strb_reg);
				mask_next = wword[7:0];
			end else if (reg_hit(aw_addr_reg, IDX_STATUS) && w_strb_reg[0]) begin
				st_clr = w_data_reg[ST_W-1:0];
			end
		end
		// sticky flags: a new event beats a clear in the same cycle
		status_next = (status_reg & ~st_clr) | st_set;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= CTRL_RESET;
			mask_reg <= MASK_RESET;
			irq_en_reg <= '0;
			status_reg <= '0;
			count_reg <= '0;
			capture_reg <= '0;
			compare_reg <= COMPARE_RESET;
			div_reg <= '0;
			pin_reg <= 1'b0;
			cap_pend_reg <= 1'b0;
			cmp_pend_reg <= 1'b0;
			cap_level_d_reg <= 1'b0;
		end else begin
			ctrl_reg <= ctrl_next;
			mask_reg <= mask_next;
			irq_en_reg <= irq_en_next;
			status_reg <= status_next;
			count_reg <= count_next;
			capture_reg <= capture_next;
			compare_reg <= compare_next;
			div_reg <= div_next;
			pin_reg <= pin_next;
			cap_pend_reg <= cap_pend_next;
			cmp_pend_reg <= cmp_pend_next;
			cap_level_d_reg <= cap_level;
		end
	end

	// request is a handshake level; the data word is the registered capture
	always_comb begin
		dma_req.req = dma_busy;
		dma_req.sel = serve_sel;
		dma_req.wdata = capture_reg;
	end

	assign compare_pin = pin_reg;
	assign irq = |(status_reg & irq_en_reg);
endmodule
`default_nettype wire
